// ===== hdl/rssc_pkg.sv
// Constants, field layout and states for the rail strobe slot configuration block.
// Assumes a two-wire serial control port and a same-clock sequencer timing engine.
//
// Contract
// - Slot register 0x23 resets 0x37; bits 7-4 rail four, 3-0 rail three.
// - Four-bit codes 3h..Ah enable the rail at the strobe equal to the code.
// - Four-bit codes 0h..2h leave the rail outside sequencer control.
// - Four-bit codes Bh..Fh leave the rail outside sequencer control.
// - Backup register 0x24 resets zero; bits 5-4 rail six, 1-0 rail five.
// - Backup code 1h enables that backup rail at strobe one.
// - Backup code 2h enables that backup rail at strobe two.
// - Backup codes 0h and 3h leave that backup rail uncontrolled.
// - Strobes one and two run only while the freshness seal flag is zero.
// - With the seal broken, backup rails five and six are never disabled.
package rssc_pkg;

    localparam logic [7:0] RSSC_SLOT_B_ADDR = 8'h23;
    localparam logic [7:0] RSSC_SLOT_B_RST = 8'h37;
    localparam logic [7:0] RSSC_BACKUP_ADDR = 8'h24;
    localparam logic [7:0] RSSC_BACKUP_RST = 8'h00;
    localparam logic [7:0] RSSC_BACKUP_WMASK = 8'h33;

    localparam int RSSC_RAIL_FOUR_LSB = 4;
    localparam int RSSC_RAIL_THREE_LSB = 0;
    localparam int RSSC_BK_SIX_LSB = 4;
    localparam int RSSC_BK_FIVE_LSB = 0;

    localparam logic [3:0] RSSC_MAIN_FIRST = 4'h3;
    localparam logic [3:0] RSSC_MAIN_LAST = 4'ha;
    localparam logic [3:0] RSSC_BK_FIRST = 4'h1;
    localparam logic [3:0] RSSC_BK_LAST = 4'h2;
    localparam logic [3:0] RSSC_SEAL_GATED_LAST = 4'h2;

    localparam logic [2:0] RSSC_BIT_LAST = 3'h7;
    localparam logic [6:0] RSSC_DEV_ADDR_DFLT = 7'h5a;

    typedef enum logic [3:0] {
        RSSC_IDLE,
        RSSC_ADDR,
        RSSC_ADDR_ACK,
        RSSC_SUB,
        RSSC_SUB_ACK,
        RSSC_WDATA,
        RSSC_WDATA_ACK,
        RSSC_RDATA,
        RSSC_RDATA_ACK
    } rssc_state_e;

endpackage : rssc_pkg

// ===== hdl/rssc_sync2.sv
// Two flip-flop synchroniser for pin inputs.
// Assumes the inputs are slow levels compared with the clock.
`timescale 1ns/1ps
`default_nettype none
module rssc_sync2 #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // Idle high matches an undriven open-drain bus.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_r <= '1;
            q <= '1;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : rssc_sync2
`default_nettype wire

// ===== hdl/rssc_slot_decode.sv
// Decodes one rail slot field against the strobe being executed.
// Assumes codes outside the window FIRST..LAST mean no sequencer control.
`timescale 1ns/1ps
`default_nettype none
module rssc_slot_decode
    import rssc_pkg::*;
#(
    parameter logic [3:0] FIRST = RSSC_MAIN_FIRST,
    parameter logic [3:0] LAST = RSSC_MAIN_LAST
) (
    // Slot field, zero extended
    input wire logic [3:0] code,
    // Current strobe
    input wire logic [3:0] strobe_num,
    output logic hit
);
    wire in_window = (code >= FIRST) && (code <= LAST);

    assign hit = in_window && (code == strobe_num);
endmodule : rssc_slot_decode
`default_nettype wire

// ===== hdl/rssc_top.sv
// Rail strobe slot registers behind a two-wire serial port, and the rail enables they steer.
// Assumes the timing engine presents strobes on ref_clk, one pulse per strobe step.
`timescale 1ns/1ps
`default_nettype none
module rssc_top
    import rssc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = RSSC_DEV_ADDR_DFLT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Serial control port
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Sequencer timing engine
    input wire logic strobe_valid,
    input wire logic [3:0] strobe_num,
    input wire logic strobe_down,
    input wire logic freshness_seal_flag,
    // Rail enables
    output logic rail_three_en,
    output logic rail_four_en,
    output logic backup_rail_five_en,
    output logic backup_rail_six_en
);
    // Pin synchronisation; edges are taken after the second stage only.
    logic [1:0] pins_s;
    logic scl_d_r;
    logic sda_d_r;

    rssc_sync2 #(.W(2)) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .d({scl_in, sda_in}),
        .q(pins_s)
    );

    wire scl_s = pins_s[1];
    wire sda_s = pins_s[0];
    wire scl_rise = scl_s && !scl_d_r;
    wire scl_fall = !scl_s && scl_d_r;
    wire start_cond = scl_s && scl_d_r && sda_d_r && !sda_s;
    wire stop_cond = scl_s && scl_d_r && !sda_d_r && sda_s;

    // Registers and serial engine state.
    logic [7:0] slot_pair_b_r;
    logic [7:0] backup_pair_r;
    logic [7:0] sub_r;
    logic [7:0] shift_r;
    logic [2:0] bit_r;
    logic rd_mode_r;
    logic master_ack_r;
    logic rise_seen_r;
    rssc_state_e state_r;
    rssc_state_e state_nxt;
    logic sda_oe_r;
    logic [3:0] rail_en_r;

    function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] pb,
                                            input logic [7:0] bk);
        if (a == RSSC_SLOT_B_ADDR) begin
            read_reg = pb;
        end else if (a == RSSC_BACKUP_ADDR) begin
            read_reg = bk & RSSC_BACKUP_WMASK;
        end else begin
            read_reg = 8'h00;
        end
    endfunction : read_reg

    wire [7:0] rd_word = read_reg(sub_r, slot_pair_b_r, backup_pair_r);
    wire [7:0] rx_byte = {shift_r[6:0], sda_s};
    wire byte_end = scl_fall && (bit_r == RSSC_BIT_LAST);
    wire addr_match = (shift_r[7:1] == DEV_ADDR);
    wire wr_commit = (state_r == RSSC_WDATA) && byte_end;
    wire wr_slot_b = wr_commit && (sub_r == RSSC_SLOT_B_ADDR);
    wire wr_backup = wr_commit && (sub_r == RSSC_BACKUP_ADDR);

    // Transfer sequencing. A start or stop always wins over the byte flow.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RSSC_IDLE: begin
                state_nxt = RSSC_IDLE;
            end
            RSSC_ADDR: begin
                if (byte_end) begin
                    state_nxt = addr_match ? RSSC_ADDR_ACK : RSSC_IDLE;
                end
            end
            RSSC_ADDR_ACK: begin
                if (scl_fall) begin
                    state_nxt = rd_mode_r ? RSSC_RDATA : RSSC_SUB;
                end
            end
            RSSC_SUB: begin
                if (byte_end) begin
                    state_nxt = RSSC_SUB_ACK;
                end
            end
            RSSC_SUB_ACK: begin
                if (scl_fall) begin
                    state_nxt = RSSC_WDATA;
                end
            end
            RSSC_WDATA: begin
                if (byte_end) begin
                    state_nxt = RSSC_WDATA_ACK;
                end
            end
            RSSC_WDATA_ACK: begin
                if (scl_fall) begin
                    state_nxt = RSSC_WDATA;
                end
            end
            RSSC_RDATA: begin
                if (byte_end) begin
                    state_nxt = RSSC_RDATA_ACK;
                end
            end
            RSSC_RDATA_ACK: begin
                if (scl_fall) begin
                    state_nxt = master_ack_r ? RSSC_RDATA : RSSC_IDLE;
                end
            end
            default: begin
                state_nxt = RSSC_IDLE;
            end
        endcase
        if (stop_cond) begin
            state_nxt = RSSC_IDLE;
        end
        if (start_cond) begin
            state_nxt = RSSC_ADDR;
        end
    end

    // Which states pull the data line low.
    wire ack_drive = (state_nxt == RSSC_ADDR_ACK) || (state_nxt == RSSC_SUB_ACK) ||
                     (state_nxt == RSSC_WDATA_ACK);
    wire rd_load = scl_fall && (state_nxt == RSSC_RDATA) && (state_r != RSSC_RDATA);
    wire [7:0] tx_src = rd_load ? rd_word : {shift_r[6:0], 1'b0};
    wire rd_drive = (state_nxt == RSSC_RDATA) && !tx_src[7];

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            state_r <= RSSC_IDLE;
            bit_r <= 3'h0;
            shift_r <= 8'h00;
            sub_r <= 8'h00;
            rd_mode_r <= 1'b0;
            master_ack_r <= 1'b0;
            rise_seen_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            state_r <= state_nxt;
            // The clock fall that closes a start carries no bit, so it must not be counted.
            if (start_cond) begin
                rise_seen_r <= 1'b0;
            end else if (scl_rise) begin
                rise_seen_r <= 1'b1;
            end
            if (start_cond || scl_fall && state_nxt != state_r) begin
                bit_r <= 3'h0;
            end else if (scl_fall && rise_seen_r) begin
                bit_r <= bit_r + 3'h1;
            end
            if (scl_rise && state_r != RSSC_RDATA) begin
                shift_r <= rx_byte;
            end else if (scl_fall && state_nxt == RSSC_RDATA) begin
                shift_r <= (state_r == RSSC_RDATA) ? {shift_r[6:0], 1'b0} : rd_word;
            end
            if (scl_rise && state_r == RSSC_ADDR && bit_r == RSSC_BIT_LAST) begin
                rd_mode_r <= sda_s;
            end
            if (scl_rise && state_r == RSSC_RDATA_ACK) begin
                master_ack_r <= !sda_s;
            end
            if (byte_end && state_r == RSSC_SUB) begin
                sub_r <= shift_r;
            end else if (wr_commit || (byte_end && state_r == RSSC_RDATA)) begin
                sub_r <= sub_r + 8'h01;
            end
            if (scl_fall || start_cond || stop_cond) begin
                sda_oe_r <= ack_drive || (scl_fall && rd_drive);
            end
        end
    end

    // Slot registers; the shift register holds the full data byte at the commit edge.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            slot_pair_b_r <= RSSC_SLOT_B_RST;
            backup_pair_r <= RSSC_BACKUP_RST;
        end else begin
            if (wr_slot_b) begin
                slot_pair_b_r <= shift_r;
            end
            if (wr_backup) begin
                backup_pair_r <= shift_r & RSSC_BACKUP_WMASK;
            end
        end
    end

    // Per-rail slot codes, zero extended so one decoder serves both field widths.
    logic [3:0] rail_code [4];
    assign rail_code[0] = slot_pair_b_r[RSSC_RAIL_THREE_LSB +: 4];
    assign rail_code[1] = slot_pair_b_r[RSSC_RAIL_FOUR_LSB +: 4];
    assign rail_code[2] = {2'b00, backup_pair_r[RSSC_BK_FIVE_LSB +: 2]};
    assign rail_code[3] = {2'b00, backup_pair_r[RSSC_BK_SIX_LSB +: 2]};

    // Early strobes belong to first power-up of the backup domain only.
    wire strobe_gated = freshness_seal_flag && (strobe_num <= RSSC_SEAL_GATED_LAST);
    wire strobe_go = strobe_valid && !strobe_gated;
    logic [3:0] rail_hit;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_rail
            localparam logic [3:0] FIRST_C = (g < 2) ? RSSC_MAIN_FIRST : RSSC_BK_FIRST;
            localparam logic [3:0] LAST_C = (g < 2) ? RSSC_MAIN_LAST : RSSC_BK_LAST;
            localparam bit IS_BACKUP = (g >= 2);

            rssc_slot_decode #(.FIRST(FIRST_C), .LAST(LAST_C)) u_dec (
                .code(rail_code[g]),
                .strobe_num(strobe_num),
                .hit(rail_hit[g])
            );

            // A broken seal keeps the backup domain alive through any power-down.
            wire hold_on = IS_BACKUP && freshness_seal_flag;

            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    rail_en_r[g] <= 1'b0;
                end else if (strobe_go && rail_hit[g]) begin
                    rail_en_r[g] <= !strobe_down || hold_on;
                end
            end
        end
    endgenerate

    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_r;
    assign rail_three_en = rail_en_r[0];
    assign rail_four_en = rail_en_r[1];
    assign backup_rail_five_en = rail_en_r[2];
    assign backup_rail_six_en = rail_en_r[3];
endmodule : rssc_top
`default_nettype wire

// ===== sim/rssc_assertions.sv
// Port-level checker for the rail strobe slot block.
// Assumes a single ref_clk domain and strobes taken on the edge where strobe_valid is high.
`timescale 1ns/1ps
`default_nettype none
module rssc_assertions (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Serial control port
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Sequencer timing engine
    input wire logic strobe_valid,
    input wire logic [3:0] strobe_num,
    input wire logic strobe_down,
    input wire logic freshness_seal_flag,
    // Rail enables
    input wire logic rail_three_en,
    input wire logic rail_four_en,
    input wire logic backup_rail_five_en,
    input wire logic backup_rail_six_en
);
    wire logic [3:0] en = {backup_rail_six_en, backup_rail_five_en, rail_four_en, rail_three_en};
    wire logic sv = strobe_valid;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_rst_quiet: assert property (disable iff (1'b0) !rst_n |=> en == 4'h0 && !sda_oe)
        else $error("Outputs not cleared by reset.");
    a_idle_hold: assert property (!sv |=> $stable(en))
        else $error("Rail enable moved without a strobe.");
    a_up_no_fall: assert property (sv && !strobe_down |=> ($past(en) & ~en) == 4'h0)
        else $error("Power-up strobe cleared a rail.");
    a_seal_skip: assert property (sv && strobe_num <= 4'h2 && freshness_seal_flag |=> $stable(en))
        else $error("Early strobe ran with seal broken.");
    a_backup_kept: assert property (freshness_seal_flag && en[3:2] != 2'h0 |=> (en[3:2] & $past(en[3:2])) == $past(en[3:2]))
        else $error("Backup rail disabled with seal broken.");
    a_main_early: assert property (sv && strobe_num <= 4'h2 |=> $stable(en[1:0]))
        else $error("Main rail moved on strobe below three.");
    a_code_high: assert property (sv && (strobe_num > 4'ha || strobe_num == 4'h0) |=> $stable(en))
        else $error("Rail moved on strobe outside any window.");
    a_backup_win: assert property (sv && strobe_num >= 4'h3 |=> $stable(en[3:2]))
        else $error("Backup rail moved on late strobe.");
    c_rail_up: cover property (sv && !strobe_down ##1 $rose(rail_four_en));
    c_seal_strobe: cover property (sv && freshness_seal_flag && strobe_num <= 4'h2);
    c_ack: cover property ($rose(sda_oe));
    c_backup_up: cover property ($rose(backup_rail_six_en));
endmodule : rssc_assertions
bind rssc_top rssc_assertions i_chk (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .strobe_valid(strobe_valid),
    .strobe_num(strobe_num), .strobe_down(strobe_down), .freshness_seal_flag(freshness_seal_flag),
    .rail_three_en(rail_three_en), .rail_four_en(rail_four_en),
    .backup_rail_five_en(backup_rail_five_en), .backup_rail_six_en(backup_rail_six_en));
`default_nettype wire

// ===== sim/rssc_tb_top.sv
// Self-checking bench for the rail strobe slot block, with a bit-banged serial master.
// Assumes the open-drain data wire is pulled up when nobody pulls it low.
`timescale 1ns/1ps
`default_nettype none
module rssc_tb_top
    import rssc_pkg::*;
;
    localparam logic [6:0] DEV = RSSC_DEV_ADDR_DFLT;
    logic ref_clk, rst_n, scl_in, sda_m, strobe_valid, strobe_down, freshness_seal_flag;
    logic [3:0] strobe_num, me;
    logic sda_out, sda_oe, rail_three_en, rail_four_en, backup_rail_five_en, backup_rail_six_en;
    logic [7:0] r23 = 8'h37, r24 = 8'h00, d;
    logic [31:0] seed = 32'h0000fb5c, v;
    int errors = 0, tests_run = 0;
    wire logic sda_w = sda_m & ~(sda_oe & ~sda_out);
    wire logic [3:0] en_seen = {backup_rail_six_en, backup_rail_five_en, rail_four_en,
                                rail_three_en};
    rssc_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .strobe_valid(strobe_valid),
        .strobe_num(strobe_num), .strobe_down(strobe_down),
        .freshness_seal_flag(freshness_seal_flag), .rail_three_en(rail_three_en),
        .rail_four_en(rail_four_en), .backup_rail_five_en(backup_rail_five_en),
        .backup_rail_six_en(backup_rail_six_en));
    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic main_hit(input logic [3:0] c, input logic [3:0] n);
        return c >= 4'h3 && c <= 4'ha && c == n;
    endfunction : main_hit
    function automatic logic bk_hit(input logic [1:0] c, input logic [3:0] n);
        return (c == 2'h1 || c == 2'h2) && n == {2'h0, c};
    endfunction : bk_hit
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    // Data only moves two clocks after SCL falls, so the synchronised pins never fake a START.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ak);
        for (int i = 7; i >= -1; i--) begin
            sda_m = (i >= 0) ? tx[i] : 1'b1;
            tick(8);
            scl_in = 1;
            tick(8);
            if (i >= 0) rx[i] = sda_w;
            else ak = !sda_w;
            scl_in = 0;
            tick(2);
        end
    endtask : xfer
    task automatic start();
        sda_m = 1;
        tick(4);
        scl_in = 1;
        tick(8);
        sda_m = 0;
        tick(8);
        scl_in = 0;
        tick(4);
    endtask : start
    task automatic stop();
        sda_m = 0;
        tick(4);
        scl_in = 1;
        tick(8);
        sda_m = 1;
        tick(8);
    endtask : stop
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] dt);
        logic [7:0] rx;
        logic [2:0] ak;
        start();
        xfer({DEV, 1'b0}, rx, ak[0]);
        xfer(a, rx, ak[1]);
        xfer(dt, rx, ak[2]);
        stop();
        check({5'h0, ak}, 8'h07);
        if (a == 8'h23) r23 = dt;
        if (a == 8'h24) r24 = dt & 8'h33;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] dt);
        logic [7:0] rx;
        logic ak;
        start();
        xfer({DEV, 1'b0}, rx, ak);
        xfer(a, rx, ak);
        start();
        xfer({DEV, 1'b1}, rx, ak);
        xfer(8'hff, dt, ak);
        stop();
    endtask : reg_rd
    task automatic strobe(input logic [3:0] n, input logic dn);
        logic s;
        s = freshness_seal_flag;
        strobe_num = n;
        strobe_down = dn;
        strobe_valid = 1;
        tick(1);
        strobe_valid = 0;
        if (!(n <= 4'h2 && s)) begin
            if (main_hit(r23[3:0], n)) me[0] = !dn;
            if (main_hit(r23[7:4], n)) me[1] = !dn;
            if (bk_hit(r24[1:0], n) && !(s && dn)) me[2] = !dn;
            if (bk_hit(r24[5:4], n) && !(s && dn)) me[3] = !dn;
        end
        check({4'h0, en_seen}, {4'h0, me});
        // One idle edge keeps the next strobe from rewriting the valid line in this step.
        tick(1);
    endtask : strobe
    initial begin
        rst_n = 0;
        scl_in = 1;
        sda_m = 1;
        strobe_valid = 0;
        strobe_num = 4'h0;
        strobe_down = 0;
        freshness_seal_flag = 0;
        me = 4'h0;
        tick(10);
        rst_n = 1;
        tick(2);
        reg_rd(8'h23, d);
        check(d, 8'h37);
        reg_rd(8'h24, d);
        check(d, 8'h00);
        strobe(4'h3, 1'b0);
        for (int c = 0; c < 16; c++) begin
            reg_wr(8'h23, {4'(c), ~4'(c)});
            for (int n = 0; n < 32; n++) strobe(4'(n), n[4]);
        end
        for (int c = 0; c < 16; c++) begin
            v = rnd();
            reg_wr(8'h24, (v[7:0] & 8'hcc) | {2'h0, 2'(c >> 2), 2'h0, 2'(c)});
            reg_rd(8'h24, d);
            check(d, r24);
            for (int n = 0; n < 8; n++) begin
                freshness_seal_flag = n[2];
                strobe(4'(n[0] + 1), n[1]);
            end
        end
        repeat (30) begin
            v = rnd();
            if (v[0]) reg_wr(v[8] ? 8'h23 : 8'h24, v[23:16]);
            freshness_seal_flag = v[1];
            repeat (4) begin
                v = rnd();
                strobe(v[3:0], v[4]);
            end
        end
        rst_n = 0;
        tick(3);
        rst_n = 1;
        me = 4'h0;
        r23 = 8'h37;
        r24 = 8'h00;
        tick(2);
        strobe(4'h0, 1'b0);
        reg_rd(8'h23, d);
        check(d, 8'h37);
        wrap_up();
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        errors++;
        wrap_up();
    end
endmodule : rssc_tb_top
`default_nettype wire
